// *** hw/hccs_pkg.sv ***
// Purpose: constants for the channel configuration and status register bank
// Assumes: byte-wide registers on an 8-bit address
// Notes:   offsets, field positions and reset values live only here
package hccs_pkg;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [7:0] OFF_RX_COUNT_LOW    = 8'h25;
   localparam logic [7:0] OFF_CHANNEL_CFG_TWO = 8'h2c;
   localparam logic [7:0] OFF_RX_COUNT_HIGH   = 8'h2d; // read side
   localparam logic [7:0] OFF_TX_COUNT_HIGH   = 8'h2d; // write side
   localparam logic [7:0] OFF_VERSION_CARRIER = 8'h2e; // read side
   localparam logic [7:0] OFF_RX_LENGTH_LIMIT = 8'h2e; // write side
   localparam logic [7:0] OFF_CHANNEL_CFG_ONE = 8'h2f;
   localparam logic [7:0] OFF_TX_SLOT_ASSIGN  = 8'h30;
   localparam logic [7:0] OFF_RX_SLOT_ASSIGN  = 8'h31;
   localparam logic [7:0] OFF_TX_SLOT_CAP     = 8'h32;
   localparam logic [7:0] OFF_RX_SLOT_CAP     = 8'h33;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_CFG   = 8'h00;
   localparam logic [7:0] RST_SLOT  = 8'h00;
   localparam logic [7:0] RST_LIMIT = 8'h00;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int CFG1_POWER_ACTIVE = 7;
   localparam int CFG1_PORT_HIGH    = 6;
   localparam int CFG1_PORT_LOW     = 5;
   localparam int CFG1_DRIVER_TYPE  = 4;
   localparam int CFG1_IDLE_FILL    = 3; // one insertion in bus modes
   localparam int CFG1_CLOCK_TOP    = 2;
   localparam int CFG2_TX_SHIFT_BOT = 5;
   localparam int CFG2_RX_SHIFT_BOT = 4;
   localparam int TXH_MODE          = 7;
   localparam int TXH_POLL          = 6;
   localparam int TXH_AUTO_START    = 5;
   localparam int LIM_CHECK_ON      = 7;
   localparam int CARRIER_BIT       = 7;

   // ***************************************************************
   // encodings and sizes
   // ***************************************************************
   localparam logic [1:0] PORT_NRZ       = 2'h0;
   localparam logic [1:0] PORT_NRZI      = 2'h2;
   localparam logic [2:0] CLOCK_MODE_TS  = 3'h5;
   localparam logic [7:0] IDLE_FLAG      = 8'h7e;
   localparam logic [2:0] ZERO_RUN_MAX   = 3'h7;
   localparam logic [11:0] RX_COUNT_MAX  = 12'hfff;
   localparam int          LEN_UNIT_LOG2 = 5; // 32-byte length steps

endpackage

// *** hw/hccs_regs.sv ***
// Purpose: per-channel configuration and status registers of a serial
//          hdlc channel, with the length check and idle/slot line logic
// Assumes: bit_tick, frame_sync and serial data come from logic on clk;
//          only carrier_detect_pin is asynchronous
// Notes:   read data stand one cycle after the read strobe, else zero
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - count-high top bits echo mode, poll, autostart
// - overflow flag when frame exceeds 4095 bytes
// - count-high low nibble is length msbs
// - carrier bit reads inverted carrier pin
// - fixed 4-bit version, three zero bits above
// - length check on/off by write
// - status byte counts toward length limit
// - suspend after (limit + 1) times 32 bytes
// - overlong frame ends as remote abort
// - power bit: standby or active
// - port field selects nrz, nrzi, bus modes
// - driver bit: open drain or push-pull
// - point-to-point idle: ones or flags
// - bus modes: idle ones and nrz
// - bus one insertion after seven zeros
// - three-bit clock mode, modes 0 to 7
// - mode 5 transmit in chosen slot
// - mode 5 receive in chosen slot
// - slot shift is two bits plus one
// - transmit bits per slot is capacity+1
// - receive bits per slot is capacity+1
// - shift offsets slot 0 to 7 bits
// - autostart: carrier high enables receiver
module hccs_regs #(
   parameter logic [3:0] VERSION_CODE = 4'h9 // arbitrary value
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rdata,
   input  wire logic       carrier_detect_pin,
   input  wire logic       bit_tick,
   input  wire logic       frame_sync,
   input  wire logic       tx_data_valid,
   input  wire logic       tx_data_bit,
   output logic            tx_bit_taken,
   output logic            txd_o,
   output logic            txd_oe_n,
   input  wire logic       rx_data_bit,
   output logic            rx_bit_valid,
   output logic            rx_bit_out,
   input  wire logic       rx_byte_stored,
   input  wire logic       rx_frame_start,
   output logic            frame_end_event,
   output logic            abort_flag,
   output logic            rx_suspended,
   output logic            rx_enable,
   output logic            power_active,
   output logic      [2:0] clock_mode
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [7:0]  cfg1;
      logic [7:0]  cfg2;
      logic [7:0]  tx_cnt_hi;
      logic [7:0]  limit;
      logic [7:0]  tx_assign;
      logic [7:0]  rx_assign;
      logic [7:0]  tx_cap;
      logic [7:0]  rx_cap;
      logic [7:0]  rdata;
      logic        car_s1;
      logic        car_s2;
      logic        car_s3;
      logic        car_lvl;
      logic [11:0] byte_cnt;
      logic        ovf;
      logic [12:0] lim_cnt;
      logic        susp;
      logic        abort;
      logic        fe_pulse;
      logic [14:0] pos;
      logic [2:0]  tx_zrun;
      logic [2:0]  rx_zrun;
      logic [2:0]  flag_idx;
      logic        tx_lvl;
      logic        rx_prev;
      logic        txd;
      logic        oe_n;
      logic        taken;
      logic        rxv;
      logic        rxb;
      logic        rx_en;
   } hccs_state_type;

   hccs_state_type st_r;
   hccs_state_type st_nxt;

   // first bit of a slot, counted from frame sync
   function automatic logic [15:0] slot_start(input logic [5:0] num,
                                              input logic [7:0] cap,
                                              input logic [2:0] shift);
      slot_start = {10'h000, num} * ({8'h00, cap} + 16'h0001)
                   + {13'h0000, shift};
   endfunction

   function automatic logic in_slot(input logic [14:0] p,
                                    input logic [7:0]  asg,
                                    input logic [7:0]  cap,
                                    input logic [2:0]  shift);
      logic [15:0] s;
      s = slot_start(asg[7:2], cap, shift);
      in_slot = ({1'b0, p} >= s) && ({1'b0, p} < s + {8'h00, cap} + 16'h0001);
   endfunction

   // ***************************************************************
   // decoded configuration
   // ***************************************************************
   logic [1:0]  port_cfg;
   logic        bus_mode;
   logic        nrzi;
   logic        ts_mode;
   logic [2:0]  tx_shift;
   logic [2:0]  rx_shift;
   logic [12:0] limit_bytes;
   logic [14:0] cur_pos;
   logic        tx_win;
   logic        rx_win;
   logic        pwr_on;
   logic        auto_start;
   logic [7:0]  rd_mux;
   logic        tx_bit;
   logic        rx_dec;

   always_comb
   begin
      pwr_on      = st_r.cfg1[hccs_pkg::CFG1_POWER_ACTIVE];
      port_cfg    = {st_r.cfg1[hccs_pkg::CFG1_PORT_HIGH],
                     st_r.cfg1[hccs_pkg::CFG1_PORT_LOW]};
      bus_mode    = port_cfg[0];
      nrzi        = (port_cfg == hccs_pkg::PORT_NRZI);
      ts_mode     = (st_r.cfg1[hccs_pkg::CFG1_CLOCK_TOP -: 3]
                     == hccs_pkg::CLOCK_MODE_TS);
      tx_shift    = {st_r.tx_assign[1:0],
                     st_r.cfg2[hccs_pkg::CFG2_TX_SHIFT_BOT]};
      rx_shift    = {st_r.rx_assign[1:0],
                     st_r.cfg2[hccs_pkg::CFG2_RX_SHIFT_BOT]};
      limit_bytes = 13'({6'h00, st_r.limit[6:0]} + 13'h0001)
                    << hccs_pkg::LEN_UNIT_LOG2;
      cur_pos     = frame_sync ? 15'h0000 : st_r.pos;
      // outside the time-slot mode the line is open on every bit
      tx_win      = !ts_mode
                    || in_slot(cur_pos, st_r.tx_assign, st_r.tx_cap,
                               tx_shift);
      rx_win      = !ts_mode
                    || in_slot(cur_pos, st_r.rx_assign, st_r.rx_cap,
                               rx_shift);
      auto_start  = st_r.tx_cnt_hi[hccs_pkg::TXH_AUTO_START];
      rd_mux      = 8'h00;
      unique case (addr)
         hccs_pkg::OFF_RX_COUNT_LOW:    rd_mux = st_r.byte_cnt[7:0];
         hccs_pkg::OFF_RX_COUNT_HIGH:
            rd_mux = {st_r.tx_cnt_hi[hccs_pkg::TXH_MODE -: 3],
                      st_r.ovf, st_r.byte_cnt[11:8]};
         hccs_pkg::OFF_VERSION_CARRIER:
            rd_mux = {!st_r.car_lvl, 3'h0, VERSION_CODE};
         hccs_pkg::OFF_CHANNEL_CFG_ONE: rd_mux = st_r.cfg1;
         hccs_pkg::OFF_CHANNEL_CFG_TWO: rd_mux = st_r.cfg2;
         default:                       rd_mux = 8'h00;
      endcase
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.rdata    = rd_en ? rd_mux : 8'h00;
      st_nxt.fe_pulse = 1'b0;
      st_nxt.taken    = 1'b0;
      st_nxt.rxv      = 1'b0;
      tx_bit          = 1'b1;
      rx_dec          = rx_data_bit;

      if (wr_en)
      begin
         unique case (addr)
            hccs_pkg::OFF_CHANNEL_CFG_ONE: st_nxt.cfg1      = wdata;
            hccs_pkg::OFF_CHANNEL_CFG_TWO: st_nxt.cfg2      = wdata;
            hccs_pkg::OFF_TX_COUNT_HIGH:   st_nxt.tx_cnt_hi = wdata;
            hccs_pkg::OFF_RX_LENGTH_LIMIT: st_nxt.limit     = wdata;
            hccs_pkg::OFF_TX_SLOT_ASSIGN:  st_nxt.tx_assign = wdata;
            hccs_pkg::OFF_RX_SLOT_ASSIGN:  st_nxt.rx_assign = wdata;
            hccs_pkg::OFF_TX_SLOT_CAP:     st_nxt.tx_cap    = wdata;
            hccs_pkg::OFF_RX_SLOT_CAP:     st_nxt.rx_cap    = wdata;
            default:                       st_nxt.cfg1      = st_r.cfg1;
         endcase
      end

      // carrier pin: three stages, level moves once stages two and three agree
      st_nxt.car_s1 = carrier_detect_pin;
      st_nxt.car_s2 = st_r.car_s1;
      st_nxt.car_s3 = st_r.car_s2;
      if (st_r.car_s2 == st_r.car_s3)
      begin
         st_nxt.car_lvl = st_r.car_s3;
      end

      // receive byte count and length check
      if (rx_frame_start)
      begin
         st_nxt.byte_cnt = 12'h000;
         st_nxt.ovf      = 1'b0;
         st_nxt.lim_cnt  = 13'h0000;
         st_nxt.susp     = 1'b0;
         st_nxt.abort    = 1'b0;
      end
      else if (rx_byte_stored && !st_r.susp)
      begin
         // the status byte arrives as a stored byte like any other
         st_nxt.byte_cnt = st_r.byte_cnt + 12'h001;
         if (st_r.byte_cnt == hccs_pkg::RX_COUNT_MAX)
         begin
            st_nxt.ovf = 1'b1;
         end
         if (st_r.lim_cnt != 13'h1fff)
         begin
            st_nxt.lim_cnt = st_r.lim_cnt + 13'h0001;
         end
         if (st_r.limit[hccs_pkg::LIM_CHECK_ON]
             && (st_r.lim_cnt >= limit_bytes))
         begin
            st_nxt.susp     = 1'b1;
            st_nxt.abort    = 1'b1;
            st_nxt.fe_pulse = 1'b1;
         end
      end

      st_nxt.rx_en = pwr_on && !st_nxt.susp
                     && (!auto_start || st_r.car_lvl);

      // bit position within the sync frame, saturating
      if (bit_tick)
      begin
         st_nxt.pos = (cur_pos == 15'h7fff) ? cur_pos : cur_pos + 15'h0001;
      end
      else if (frame_sync)
      begin
         st_nxt.pos = 15'h0000;
      end

      // transmit line
      if (!pwr_on)
      begin
         st_nxt.txd  = 1'b1;
         st_nxt.oe_n = 1'b1;
      end
      else
      begin
         if (bit_tick && tx_win)
         begin
            if (bus_mode && st_r.cfg1[hccs_pkg::CFG1_IDLE_FILL]
                && (st_r.tx_zrun == hccs_pkg::ZERO_RUN_MAX))
            begin
               tx_bit = 1'b1;
            end
            else if (tx_data_valid)
            begin
               tx_bit       = tx_data_bit;
               st_nxt.taken = 1'b1;
            end
            else if (!bus_mode && st_r.cfg1[hccs_pkg::CFG1_IDLE_FILL])
            begin
               tx_bit          = hccs_pkg::IDLE_FLAG[st_r.flag_idx];
               st_nxt.flag_idx = st_r.flag_idx + 3'h1;
            end
            else
            begin
               tx_bit = 1'b1;
            end
            if (!tx_bit && st_r.tx_zrun != hccs_pkg::ZERO_RUN_MAX)
            begin
               st_nxt.tx_zrun = st_r.tx_zrun + 3'h1;
            end
            else if (tx_bit)
            begin
               st_nxt.tx_zrun = 3'h0;
            end
            // nrzi: a zero flips the line, a one holds it
            st_nxt.tx_lvl = nrzi ? (tx_bit ? st_r.tx_lvl : !st_r.tx_lvl)
                                 : tx_bit;
            st_nxt.txd    = st_nxt.tx_lvl;
         end
         else if (bit_tick)
         begin
            // out of slot the pin still drives; open drain avoids clashes
            st_nxt.txd = 1'b1;
         end
         st_nxt.oe_n = st_r.cfg1[hccs_pkg::CFG1_DRIVER_TYPE]
                       ? 1'b0 : st_nxt.txd;
      end

      // receive line with one deletion
      if (pwr_on && bit_tick && rx_win)
      begin
         if (nrzi)
         begin
            rx_dec = (rx_data_bit == st_r.rx_prev);
         end
         st_nxt.rx_prev = rx_data_bit;
         if (bus_mode && st_r.cfg1[hccs_pkg::CFG1_IDLE_FILL]
             && (st_r.rx_zrun == hccs_pkg::ZERO_RUN_MAX))
         begin
            st_nxt.rx_zrun = 3'h0;
         end
         else
         begin
            st_nxt.rxv = 1'b1;
            st_nxt.rxb = rx_dec;
            if (rx_dec)
            begin
               st_nxt.rx_zrun = 3'h0;
            end
            else if (st_r.rx_zrun != hccs_pkg::ZERO_RUN_MAX)
            begin
               st_nxt.rx_zrun = st_r.rx_zrun + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r           <= '0;
         st_r.cfg1      <= hccs_pkg::RST_CFG;
         st_r.cfg2      <= hccs_pkg::RST_CFG;
         st_r.limit     <= hccs_pkg::RST_LIMIT;
         st_r.tx_cap    <= hccs_pkg::RST_SLOT;
         st_r.rx_cap    <= hccs_pkg::RST_SLOT;
         st_r.car_s1    <= 1'b1;
         st_r.car_s2    <= 1'b1;
         st_r.car_s3    <= 1'b1;
         st_r.car_lvl   <= 1'b1;
         st_r.txd       <= 1'b1;
         st_r.oe_n      <= 1'b1;
         st_r.tx_lvl    <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rdata           = st_r.rdata;
   assign tx_bit_taken    = st_r.taken;
   assign txd_o           = st_r.txd;
   assign txd_oe_n        = st_r.oe_n;
   assign rx_bit_valid    = st_r.rxv;
   assign rx_bit_out      = st_r.rxb;
   assign frame_end_event = st_r.fe_pulse;
   assign abort_flag      = st_r.abort;
   assign rx_suspended    = st_r.susp;
   assign rx_enable       = st_r.rx_en;
   assign power_active    = st_r.cfg1[hccs_pkg::CFG1_POWER_ACTIVE];
   assign clock_mode      = st_r.cfg1[hccs_pkg::CFG1_CLOCK_TOP -: 3];

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_count_mode_echo: assert property (
      rd_en && addr == hccs_pkg::OFF_RX_COUNT_HIGH
      |=> rdata[7:5] == $past(st_r.tx_cnt_hi[7:5]))
      else $error("count high top bits do not echo transmit settings");
   a_overflow_set: assert property (rx_byte_stored && !rx_frame_start
      && !st_r.susp && st_r.byte_cnt == 12'hfff |=> st_r.ovf)
      else $error("overflow flag not set past 4095 bytes");
   a_len_msb_read: assert property (
      rd_en && addr == hccs_pkg::OFF_RX_COUNT_HIGH
      |=> rdata[3:0] == $past(st_r.byte_cnt[11:8]))
      else $error("length msbs wrong on read");
   a_carrier_inv: assert property (
      rd_en && addr == hccs_pkg::OFF_VERSION_CARRIER
      |=> rdata[7] == !$past(st_r.car_lvl))
      else $error("carrier bit not inverted pin level");
   a_version_field: assert property (
      rd_en && addr == hccs_pkg::OFF_VERSION_CARRIER
      |=> rdata[6:0] == {3'h0, VERSION_CODE})
      else $error("version field wrong");
   a_check_off_quiet: assert property (
      !st_r.limit[7] && !wr_en && !st_r.susp |=> !st_r.susp)
      else $error("suspended with length check off");
   a_limit_abort: assert property (st_r.limit[7] && rx_byte_stored
      && !rx_frame_start && !st_r.susp && st_r.lim_cnt >= limit_bytes
      |=> frame_end_event && abort_flag
      ##1 !frame_end_event && (abort_flag || $past(rx_frame_start)))
      else $error("overlong frame not ended as abort");
   a_standby_float: assert property (!pwr_on |=> txd_oe_n && txd_o)
      else $error("pin driven in standby");
   a_push_pull: assert property (
      pwr_on && st_r.cfg1[4] && !wr_en |=> !txd_oe_n)
      else $error("push-pull pin not driven");
   a_one_insert: assert property (
      pwr_on && bus_mode && st_r.cfg1[3] && bit_tick && tx_win
      && st_r.tx_zrun == 3'h7 |=> txd_o && !tx_bit_taken)
      else $error("no inserted one after seven zeros");
   a_autostart_rx: assert property (
      pwr_on && auto_start && !st_r.car_lvl |=> !rx_enable)
      else $error("receiver enabled with carrier low");

   c_overflow:   cover property (st_r.ovf);
   c_limit_hit:  cover property (frame_end_event);
   c_flag_idle:  cover property (bit_tick && !bus_mode && st_r.cfg1[3]
                                 && !tx_data_valid ##1 !txd_o);
   c_slot_mode:  cover property (ts_mode && bit_tick && tx_win ##1 tx_bit_taken);

endmodule // hccs_regs

`default_nettype wire

// *** bench/test_hccs_regs.sv ***
// Purpose: self-checking bench for the channel config and status registers
// Assumes: all inputs driven by non-blocking assignment at rising clk
// Notes:   serial ticks are two cycles apart so every result has settled
`timescale 1ns/1ps
`default_nettype none
module test_hccs_regs;
   localparam logic [3:0] VER = 4'h6; // arbitrary value
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] rdata;
   logic       car_pin = 1'b1;
   logic       bit_tick = 1'b0;
   logic       frame_sync = 1'b0;
   logic       tx_data_valid = 1'b1;
   logic       tx_data_bit = 1'b1;
   logic       tx_bit_taken, txd_o, txd_oe_n, rx_bit_valid, rx_bit_out;
   logic       rx_data_bit = 1'b1;
   logic       rx_byte_stored = 1'b0;
   logic       rx_frame_start = 1'b0;
   logic       frame_end_event, abort_flag, rx_suspended, rx_enable;
   logic       power_active;
   logic [2:0] clock_mode;
   logic [7:0] tk, vd, tx, oe, rb;
   logic [7:0] rx_st;
   logic [7:0] mode_st;
   logic       found;
   int         errors = 0;
   int         num_checks = 0;

   hccs_regs #(.VERSION_CODE(VER)) uut (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .carrier_detect_pin(car_pin), .bit_tick(bit_tick),
      .frame_sync(frame_sync), .tx_data_valid(tx_data_valid),
      .tx_data_bit(tx_data_bit), .tx_bit_taken(tx_bit_taken),
      .txd_o(txd_o), .txd_oe_n(txd_oe_n), .rx_data_bit(rx_data_bit),
      .rx_bit_valid(rx_bit_valid), .rx_bit_out(rx_bit_out),
      .rx_byte_stored(rx_byte_stored), .rx_frame_start(rx_frame_start),
      .frame_end_event(frame_end_event), .abort_flag(abort_flag),
      .rx_suspended(rx_suspended), .rx_enable(rx_enable),
      .power_active(power_active), .clock_mode(clock_mode));

   assign rx_st   = {5'h0, frame_end_event, abort_flag, rx_suspended};
   assign mode_st = {power_active, 4'h0, clock_mode};

   always #2.5 clk = ~clk;

   // ***************************************************************
   // access tasks
   // ***************************************************************
   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [7:0] a,
                     input logic [7:0] exp);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk(name, exp, rdata);
   endtask

   task automatic frame_start();
      @(posedge clk);
      rx_frame_start <= 1'b1;
      @(posedge clk);
      rx_frame_start <= 1'b0;
      @(negedge clk);
   endtask

   task automatic put_bytes(input int n);
      repeat (n)
      begin
         @(posedge clk);
         rx_byte_stored <= 1'b1;
         @(posedge clk);
         rx_byte_stored <= 1'b0;
      end
      @(negedge clk);
   endtask

   // one serial bit per tick, bit i of each pattern goes with tick i
   task automatic ticks(input logic [7:0] txp, input logic [7:0] rxp,
                        input logic fs);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         bit_tick    <= 1'b1;
         frame_sync  <= fs && (i == 0);
         tx_data_bit <= txp[i];
         rx_data_bit <= rxp[i];
         @(posedge clk);
         bit_tick   <= 1'b0;
         frame_sync <= 1'b0;
         @(negedge clk);
         tk[i] = tx_bit_taken;
         vd[i] = rx_bit_valid;
         tx[i] = txd_o;
         oe[i] = txd_oe_n;
         rb[i] = rx_bit_out;
      end
   endtask

   task automatic give_verdict();
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ***************************************************************
   // tests
   // ***************************************************************
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd("cfg one reset", hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h00);
      wr(hccs_pkg::OFF_TX_COUNT_HIGH, 8'he0);
      rd("count echo", hccs_pkg::OFF_RX_COUNT_HIGH, 8'he0);
      wr(hccs_pkg::OFF_TX_COUNT_HIGH, 8'h20);
      rd("count echo", hccs_pkg::OFF_RX_COUNT_HIGH, 8'h20);
      rd("carrier idle", hccs_pkg::OFF_VERSION_CARRIER, {4'h0, VER});
      @(posedge clk);
      car_pin <= 1'b0;
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h80);
      repeat (5) @(posedge clk);
      rd("carrier on", hccs_pkg::OFF_VERSION_CARRIER, {4'h8, VER});
      chk("autostart off", 8'h00, {7'h0, rx_enable});
      @(posedge clk);
      car_pin <= 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("autostart on", 8'h01, {7'h0, rx_enable});
      for (int m = 0; m < 8; m++)
      begin
         wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h80 | m[7:0]);
         rd("cfg one", hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h80 | m[7:0]);
         chk("mode", 8'h80 | m[7:0], mode_st);
      end
      // limit of one and two 32-byte units, abort on the byte beyond
      for (int l = 0; l < 2; l++)
      begin
         wr(hccs_pkg::OFF_RX_LENGTH_LIMIT, 8'h80 | l[7:0]);
         frame_start();
         put_bytes((l + 1) * 32);
         chk("no abort", 8'h00, rx_st);
         put_bytes(1);
         chk("abort", 8'h07, rx_st);
      end
      put_bytes(5);
      rd("count low", hccs_pkg::OFF_RX_COUNT_LOW, 8'h41);
      wr(hccs_pkg::OFF_RX_LENGTH_LIMIT, 8'h01);
      frame_start();
      put_bytes(300);
      chk("check off", 8'h00, {6'h0, abort_flag, rx_suspended});
      rd("count low", hccs_pkg::OFF_RX_COUNT_LOW, 8'h2c);
      rd("count high", hccs_pkg::OFF_RX_COUNT_HIGH, 8'h21);
      put_bytes(3796);
      rd("overflow", hccs_pkg::OFF_RX_COUNT_HIGH, 8'h30);
      wr(hccs_pkg::OFF_TX_COUNT_HIGH, 8'h00);
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h90);
      ticks(8'ha5, 8'h3c, 1'b0);
      chk("nrz", 8'ha5, tx);
      chk("rx nrz", 8'h3c, rb);
      chk("push-pull", 8'h00, oe);
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h80);
      ticks(8'ha5, 8'hff, 1'b0);
      chk("open drain", 8'ha5, oe);
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'hd0);
      ticks(8'h00, 8'h0f, 1'b0);
      chk("nrzi", 8'h7f, {1'b0, tx[7:1] ^ tx[6:0]});
      chk("nrzi rx", 8'hef, rb);
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'hf0);
      ticks(8'ha5, 8'hff, 1'b0);
      chk("bus nrz", 8'ha5, tx);
      @(posedge clk);
      tx_data_valid <= 1'b0;
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h90);
      ticks(8'h00, 8'hff, 1'b0);
      chk("idle ones", 8'hff, tx);
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h98);
      ticks(8'h00, 8'hff, 1'b0);
      found = 1'b0;
      for (int r = 0; r < 8; r++)
         if (8'({tx, tx} >> r) == 8'h7e)
            found = 1'b1;
      chk("idle flag", 8'h01, {7'h0, found});
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'hb8);
      ticks(8'h00, 8'hff, 1'b0);
      chk("bus idle", 8'hff, tx);
      @(posedge clk);
      tx_data_valid <= 1'b1;
      ticks(8'h00, 8'h80, 1'b0);
      chk("insert line", 8'h80, tx);
      chk("insert taken", 8'h7f, tk);
      chk("delete", 8'h7f, vd);
      chk("delete data", 8'h00, {1'b0, rb[6:0]});
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h10);
      ticks(8'hff, 8'hff, 1'b0);
      chk("standby", 8'h00, tk);
      chk("standby pin", 8'hff, oe);
      // mode 5: tx slot 1 of 2 bits shift 1, rx slot 2 of 1 bit shift 2
      wr(hccs_pkg::OFF_TX_SLOT_ASSIGN, 8'h04);
      wr(hccs_pkg::OFF_TX_SLOT_CAP, 8'h01);
      wr(hccs_pkg::OFF_RX_SLOT_ASSIGN, 8'h09);
      wr(hccs_pkg::OFF_RX_SLOT_CAP, 8'h00);
      wr(hccs_pkg::OFF_CHANNEL_CFG_TWO, 8'h20);
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h85);
      ticks(8'hff, 8'hff, 1'b1);
      chk("tx slot", 8'h18, tk);
      chk("rx slot", 8'h10, vd);
      wr(hccs_pkg::OFF_CHANNEL_CFG_ONE, 8'h90);
      ticks(8'hff, 8'hff, 1'b1);
      chk("tx no slot", 8'hff, tk);
      chk("rx no slot", 8'hff, vd);
      give_verdict();
   end

   // the whole run needs about 8700 cycles, so 40000 means a hang
   initial
   begin
      #200000;
      errors++;
      give_verdict();
   end
endmodule // test_hccs_regs
`default_nettype wire
